// ===== testbench/ssw_cpu.sv
`timescale 1ns/10ps
`default_nettype none
module ssw_cpu (
    input wire logic mclk,
    input wire logic en,
    input wire logic held,
    output logic     kick
);
    int   t     = 0;
    logic level = 1'b0;
    assign kick = level;
    // kicks every 50 cycles, well inside the shortest timeout; idle while held in reset
    always @(posedge mclk) begin
        t <= (held || !en || t == 49) ? 0 : t + 1;
        if (t == 49) level <= #2 ~level;
    end
endmodule // ssw_cpu
`default_nettype wire

// ===== testbench/ssw_props.sv
`timescale 1ns/10ps
`default_nettype none
module ssw_props #(parameter int STRETCH_CYC = 20, parameter int WDOG_CYC = 100) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic supplyLow,
    input wire logic watchdogKickInput,
    input wire logic kickFloat,
    input wire logic resetPinIn,
    input wire ssw_pkg::ssw_odpin_t resetPin,
    input wire ssw_pkg::ssw_status_t status
);
    int hi, lo;
    always_ff @(posedge mclk or negedge rst_b)
        if (!rst_b) hi <= 0; else hi <= resetPin.oe ? hi + 1 : 0;
    always_ff @(posedge mclk or negedge rst_b)
        if (!rst_b) lo <= 0; else lo <= resetPin.oe ? 0 : lo + 1;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence expPulse; $rose(resetPin.oe) ##1 !status.wdogExpired; endsequence
    a_supply_forces: assert property (supplyLow |=> resetPin.oe)
        else $error("no reset on low supply");
    a_pin_open_drain: assert property (resetPin.out == 1'b0)
        else $error("pin driven high");
    a_held_tracks: assert property (status.resetHeld == resetPin.oe)
        else $error("status differs from pin");
    a_stretch_length: assert property ($fell(resetPin.oe) |-> hi >= STRETCH_CYC)
        else $error("reset too short");
    a_wdog_period: assert property ($rose(resetPin.oe) |-> lo == WDOG_CYC || $past(supplyLow))
        else $error("wrong timeout");
    a_wdog_disabled: assert property (kickFloat || supplyLow |-> !status.wdogArmed)
        else $error("watchdog armed");
    a_kick_restart: assert property ($changed(watchdogKickInput) && !resetPin.oe && !supplyLow |=> !resetPin.oe)
        else $error("kick ignored");
    a_expiry_pulse: assert property (status.wdogExpired |-> expPulse)
        else $error("bad expiry pulse");
endmodule // ssw_props
`default_nettype wire

// ===== testbench/ssw_supervisor_test.sv
`timescale 1ns/10ps
`default_nettype none
module ssw_supervisor_test;
    localparam int S = 20, W = 100;
    logic mclk = 0, rst_b = 0, supplyLow = 0, kickFloat = 0, cpuEn = 0;
    logic kick;
    ssw_pkg::ssw_odpin_t resetPin;
    ssw_pkg::ssw_status_t status;
    int fail_count = 0, n_compared = 0, cyc = 0, n;
    always #20 mclk = ~mclk;
    ssw_supervisor #(.CNT_W(8), .STRETCH_CYC(S), .WDOG_CYC(W)) dut (.mclk, .rst_b, .supplyLow,
        .watchdogKickInput(kick), .kickFloat, .resetPinIn(!resetPin.oe), .resetPin, .status);
    ssw_cpu cpu (.mclk, .en(cpuEn), .held(resetPin.oe), .kick);
    ////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task end_of_test;
        if (fail_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task tick(input int k);
        repeat (k) @(posedge mclk);
        #2;
    endtask
    task wait_oe(input logic v);
        n = 0;
        while (resetPin.oe !== v) begin tick(1); n++; end
    endtask
    task count_high(input int k);
        n = 0;
        repeat (k) begin tick(1); n += resetPin.oe; end
    endtask
    ////////////////////////////////////////
    task t_static;
        repeat (2) begin
            wait_oe(1);
            chk(n, W);
            chk(status.wdogExpired, 1'b1);
            wait_oe(0);
            chk(n >= S, 1);
        end
    endtask
    task t_kick;
        cpuEn = 1;
        count_high(400);
        chk(n, 0);
    endtask
    task t_float;
        cpuEn = 0;
        kickFloat = 1;
        count_high(300);
        chk(n, 0);
        chk(status.wdogArmed, 1'b0);
    endtask
    task t_supply;
        supplyLow = 1;
        tick(1);
        chk(resetPin, 2'h1);
        chk(status, 3'h4);
        kickFloat = 0;
        count_high(200);
        chk(n, 200);
        supplyLow = 0;
        wait_oe(0);
        chk(n, S + 1);
    endtask
    initial begin
        tick(20);
        rst_b = 1;
        wait_oe(0);
        chk(n >= S, 1);
        t_static;
        t_kick;
        t_float;
        t_supply;
        end_of_test;
    end
    always @(posedge mclk) if (++cyc == 3000) begin fail_count++; end_of_test; end
endmodule // ssw_supervisor_test
bind ssw_supervisor ssw_props #(.STRETCH_CYC(STRETCH_CYC), .WDOG_CYC(WDOG_CYC)) props (.mclk, .rst_b,
    .supplyLow, .watchdogKickInput, .kickFloat, .resetPinIn, .resetPin, .status);
`default_nettype wire

// ===== verilog/ssw_defines.svh
`ifndef SSW_DEFINES_SVH
`define SSW_DEFINES_SVH

// time base
`define SSW_CLK_HZ         25000000
`define SSW_CYC_PER_MS     (`SSW_CLK_HZ / 1000)

// reset stretch after supply recovery or expiry
`define SSW_STRETCH_MIN_MS 140
`define SSW_STRETCH_MS     200
`define SSW_STRETCH_CYC    (`SSW_STRETCH_MS * `SSW_CYC_PER_MS)

// watchdog timeout, fixed
`define SSW_WDOG_MIN_MS    1000
`define SSW_WDOG_MS        1600
`define SSW_WDOG_CYC       (`SSW_WDOG_MS * `SSW_CYC_PER_MS)

// counter width covering both counts
`define SSW_CNT_W          26

`endif

// ===== verilog/ssw_pkg.sv
`default_nettype none
package ssw_pkg;

    // one-hot supervisor states
    typedef enum logic [2:0] {
        SSW_SUPPLY  = 3'h1,
        SSW_STRETCH = 3'h2,
        SSW_RUN     = 3'h4
    } ssw_state_t;

    // open-drain pin drive pair
    typedef struct packed {
        logic out;
        logic oe;
    } ssw_odpin_t;

    // status seen by the rest of the chip
    typedef struct packed {
        logic resetHeld;
        logic wdogArmed;
        logic wdogExpired;
    } ssw_status_t;

endpackage
`default_nettype wire

// ===== verilog/ssw_supervisor.sv
// Notes on behaviour
// - reset output driven low whenever supply-low indication is active
// - reset stays asserted at least 140 ms, nominally 200 ms, after recovery
// - reset pin is active-low open drain: pulls low or releases
// - static kick longer than timeout gives reset pulse of at least 140 ms
// - watchdog timeout fixed, never below 1.0 s
// - any kick edge before timeout restarts the watchdog count
// - static kick repeats reset pulses once per watchdog period
// - fresh watchdog period starts when reset goes inactive
// - floating kick input disables watchdog entirely
// - watchdog held disabled while supply-low indication active
`timescale 1ns/10ps
`default_nettype none
`include "ssw_defines.svh"

module ssw_supervisor #(
    parameter int unsigned CNT_W       = `SSW_CNT_W,
    parameter int unsigned STRETCH_CYC = `SSW_STRETCH_CYC,
    parameter int unsigned WDOG_CYC    = `SSW_WDOG_CYC
) (
    input  wire logic                mclk,
    input  wire logic                rst_b,
    input  wire logic                supplyLow,
    input  wire logic                watchdogKickInput,
    input  wire logic                kickFloat,
    input  wire logic                resetPinIn,
    output var ssw_pkg::ssw_odpin_t  resetPin,
    output var ssw_pkg::ssw_status_t status
);

    ////////////////////////////////////////////////////////////////
    // declarations

    ssw_pkg::ssw_state_t state_q;
    ssw_pkg::ssw_state_t state_d;

    logic             kickPrev_q;
    logic             expired_q;
    logic             resetDrive_q;
    logic             kickEdge;
    logic             wdogArmed;
    logic             inStretch;
    logic             inRun;
    logic             stretchClear;
    logic             stretchDone;
    logic             wdogClear;
    logic             wdogAtLast;
    logic             wdogDone;

    ////////////////////////////////////////////////////////////////
    // kick edge and watchdog enable

    // inputs arrive already synchronised
    assign kickEdge = watchdogKickInput ^ kickPrev_q;

    assign inStretch = (state_q == ssw_pkg::SSW_STRETCH);
    assign inRun     = (state_q == ssw_pkg::SSW_RUN);

    assign wdogArmed = inRun
                     && !kickFloat
                     && !supplyLow;

    // a kick in the expiry cycle still wins
    assign wdogDone = wdogArmed && !kickEdge
                    && wdogAtLast;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            kickPrev_q <= 1'b0;
        end else begin
            kickPrev_q <= watchdogKickInput;
        end
    end

    ////////////////////////////////////////////////////////////////
    // supervisor state

    always_comb begin
        state_d = state_q;
        case (state_q)
            ssw_pkg::SSW_SUPPLY: begin
                if (!supplyLow) begin
                    state_d = ssw_pkg::SSW_STRETCH;
                end
            end
            ssw_pkg::SSW_STRETCH: begin
                if (supplyLow) begin
                    state_d = ssw_pkg::SSW_SUPPLY;
                end else if (stretchDone) begin
                    state_d = ssw_pkg::SSW_RUN;
                end
            end
            ssw_pkg::SSW_RUN: begin
                if (supplyLow) begin
                    state_d = ssw_pkg::SSW_SUPPLY;
                end else if (wdogDone) begin
                    state_d = ssw_pkg::SSW_STRETCH;
                end
            end
            default: begin
                state_d = ssw_pkg::SSW_SUPPLY;
            end
        endcase
    end

    // start out holding reset, as if the supply had just come up
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ssw_pkg::SSW_SUPPLY;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // reset stretch counter

    // counts only in stretch; any supply dip restarts the full stretch
    assign stretchClear = !inStretch;

    ssw_cycle_cnt #(
        .CNT_W (CNT_W),
        .LAST  (STRETCH_CYC - 1)
    ) stretchTimer (
        .mclk   (mclk),
        .rst_b  (rst_b),
        .clear  (stretchClear),
        .atLast (stretchDone)
    );

    ////////////////////////////////////////////////////////////////
    // watchdog counter

    // cleared outside run so each release starts a full period
    assign wdogClear = !wdogArmed || kickEdge || wdogDone;

    ssw_cycle_cnt #(
        .CNT_W (CNT_W),
        .LAST  (WDOG_CYC - 1)
    ) wdogTimer (
        .mclk   (mclk),
        .rst_b  (rst_b),
        .clear  (wdogClear),
        .atLast (wdogAtLast)
    );

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            expired_q <= 1'b0;
        end else begin
            expired_q <= wdogDone;
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs

    // loaded from the next state, so the pin moves with the state register
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            resetDrive_q <= 1'b1;
        end else begin
            resetDrive_q <= (state_d != ssw_pkg::SSW_RUN);
        end
    end

    // pin level never driven high; the pull-up owns the released state
    assign resetPin.out = 1'b0;
    assign resetPin.oe  = resetDrive_q;

    assign status.resetHeld   = resetDrive_q;
    assign status.wdogArmed   = wdogArmed;
    assign status.wdogExpired = expired_q;

    // line readback not needed; other drivers may hold it low too
    logic unusedPin;
    assign unusedPin = resetPinIn;

endmodule // ssw_supervisor

////////////////////////////////////////////////////////////////
// cycle counter shared by the stretch and watchdog timing

module ssw_cycle_cnt #(
    parameter int unsigned CNT_W = 8,
    parameter int unsigned LAST  = 1
) (
    input  wire logic mclk,
    input  wire logic rst_b,
    input  wire logic clear,
    output var  logic atLast
);

    localparam logic [CNT_W-1:0] LAST_VAL = CNT_W'(LAST);

    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;

    // holds at the last value so a long stretch cannot wrap to zero
    always_comb begin
        count_d = count_q;
        if (clear) begin
            count_d = '0;
        end else if (count_q != LAST_VAL) begin
            count_d = count_q + CNT_W'(1);
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    assign atLast = (count_q == LAST_VAL);

endmodule // ssw_cycle_cnt
`default_nettype wire
